// ===== hw/csp_map.svh
// Purpose: offsets, field positions, reset values and field codes
// Assumes: included by the setup module only
// Notes:   definitions only
`ifndef CSP_MAP_SVH
`define CSP_MAP_SVH
// Register select codes on the two upper data lines
`define CSP_SEL_SETUP0      2'h0
`define CSP_SEL_SETUP1      2'h1
// Field positions of the primary setup register
`define CSP_BIT_EXTREF      0
`define CSP_BIT_SINGLE      1
`define CSP_BIT_PWRDN       2
`define CSP_CHAN_LSB        3
`define CSP_CHAN_MSB        7
`define CSP_TEST_LSB        8
`define CSP_TEST_MSB        9
// Reset value: differential channel selected
`define CSP_SETUP0_RESET    10'h020
// Channel selection codes, bits 7..3
`define CSP_CHAN_POS        5'h00
`define CSP_CHAN_NEG        5'h01
`define CSP_CHAN_DIFF       5'h04
`define CSP_CHAN_SCAN       5'h11
// Test field codes
`define CSP_TEST_NORMAL     2'h0
`define CSP_TEST_UPPER      2'h1
`define CSP_TEST_MID        2'h2
`define CSP_TEST_LOWER      2'h3
// Block size value, not used: the block size comes from TRIGGER_LEVEL
`define CSP_TRIG_RESET      4'h1
`endif

// ===== hw/csp_pkg.sv
// Purpose: shared types of the converter setup block
// Assumes: nothing
// Notes:   numbers live in csp_map.svh
package csp_pkg;
    // Source chosen for the next conversion
    typedef enum {
        CSP_SRC_POS,
        CSP_SRC_NEG,
        CSP_SRC_DIFF,
        CSP_SRC_UPPER,
        CSP_SRC_MID,
        CSP_SRC_LOWER,
        CSP_SRC_NONE
    } csp_src_e;
    // Sequencer states
    typedef enum {
        CSP_ST_IDLE,
        CSP_ST_CONV
    } csp_state_e;
    typedef logic [11:0] csp_sample_t;
endpackage : csp_pkg

// ===== hw/csp_stream_if.sv
// Purpose: valid/ready sample stream between converter and buffer
// Assumes: single clock domain
// Notes:   source drives valid and data, sink drives ready
`timescale 1ns/1ns
interface csp_stream_if #(parameter int WIDTH = 12);
    logic             valid; // Word offered
    logic             ready; // Word accepted
    logic [WIDTH-1:0] data;  // Payload
    modport src  (output valid, output data, input ready);
    modport sink (input valid, input data, output ready);
endinterface : csp_stream_if

// ===== hw/csp_fifo.sv
// Purpose: small sample FIFO, flip-flop storage
// Assumes: DEPTH is a power of two
// Notes:   full and empty derived from wrapping pointers
`timescale 1ns/1ns
module csp_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 4
) (
    input  wire logic clk,
    input  wire logic rst_n,
    csp_stream_if.sink wr,
    csp_stream_if.src  rd
);
    localparam int AW = $clog2(DEPTH);
    // Refuse depths the wrapping pointers cannot serve
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("csp_fifo: DEPTH must be a power of two >= 2");
    end

    ////////////////////////////////////////////////////////////////////
    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW:0]      wp_q, wp_d;      // Write pointer, extra wrap bit
    logic [AW:0]      rp_q, rp_d;      // Read pointer
    logic             full, empty;

    assign full     = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty    = (wp_q == rp_q);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem_q[rp_q[AW-1:0]];

    // Next pointers and storage
    always_comb begin
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        if (wr.valid && !full) begin
            mem_d[wp_q[AW-1:0]] = wr.data;
            wp_d = wp_q + 1'b1;
        end
        if (rd.ready && !empty)
            rp_d = rp_q + 1'b1;
    end

    // Register stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
        mem_q <= mem_d;
    end
endmodule : csp_fifo

// ===== hw/csp_setup.sv
// Purpose: primary converter setup register and conversion sequencer
// Assumes: pins synchronous to CORE_CLK; host keeps legal channel codes
// Notes:   conversion result supplied on CONV_RESULT by the analog core
`timescale 1ns/1ns
`include "csp_map.svh"
module csp_setup #(
    parameter int FIFO_DEPTH = 4
) (
    input  wire logic               CORE_CLK,
    input  wire logic               NRST,
    input  wire logic               BUS_WRITE,      // Write strobe, 1 cycle
    input  wire logic [11:0]        BUS_DATA,       // Data lines 11..0
    input  wire logic               BUS_READ,       // Read strobe, 1 cycle
    input  wire logic               CONVERSION_CLOCK_PIN,
    input  wire logic [3:0]         TRIGGER_LEVEL,  // Block size
    input  wire csp_pkg::csp_sample_t CONV_RESULT,  // Core result
    output logic                    BLOCK_READY_FLAG,
    output logic                    SAMPLE_VALID,
    output csp_pkg::csp_sample_t    SAMPLE_DATA,
    output logic [9:0]              SETUP_READBACK,
    output logic                    EXT_REF_SELECT,
    output logic                    HOLD_INPUTS,
    output logic [2:0]              SOURCE_SELECT,
    output logic                    OVERRUN
);
    import csp_pkg::*;

    // Refuse a buffer shallower than two words
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("csp_setup: FIFO_DEPTH too small");
    end

    ////////////////////////////////////////////////////////////////////
    // State
    logic [9:0]  setup_q, setup_d;       // Primary setup register
    logic        pin_q, pin_d;           // Previous pin level
    logic        alt_q, alt_d;           // Autoscan phase, 1 = negative
    logic [3:0]  count_q, count_d;       // Samples since last block
    logic        ready_q, ready_d;       // Block ready output
    logic        hold_q, hold_d;         // Hold pulse
    logic        ovr_q, ovr_d;           // Sample lost to full buffer
    logic [2:0]  src_q, src_d;           // Current source code
    logic        out_v_q, out_v_d;       // Output word valid
    csp_sample_t out_q, out_d;           // Output word
    csp_state_e  st_q, st_d;             // Sequencer state

    ////////////////////////////////////////////////////////////////////
    // Buffer in the data path
    csp_stream_if #(.WIDTH(12)) to_buf ();
    csp_stream_if #(.WIDTH(12)) from_buf ();

    csp_fifo #(
        .WIDTH (12),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (CORE_CLK),
        .rst_n (NRST),
        .wr    (to_buf),
        .rd    (from_buf)
    );

    ////////////////////////////////////////////////////////////////////
    // Decode
    logic       fall;          // Falling edge on the clock pin
    logic       pwr_down;      // Converter idle
    logic [4:0] chan;          // Channel code bits 7..3
    logic [1:0] test;          // Test field
    csp_src_e   src_now;       // Source for this conversion

    assign fall     = pin_q && !CONVERSION_CLOCK_PIN;
    assign pwr_down = setup_q[`CSP_BIT_PWRDN];
    assign chan     = setup_q[`CSP_CHAN_MSB:`CSP_CHAN_LSB];
    assign test     = setup_q[`CSP_TEST_MSB:`CSP_TEST_LSB];

    // Source choice from test field, then channel code
    always_comb begin
        case (test)
            `CSP_TEST_UPPER: src_now = CSP_SRC_UPPER;
            `CSP_TEST_MID:   src_now = CSP_SRC_MID;
            `CSP_TEST_LOWER: src_now = CSP_SRC_LOWER;
            default: begin
                case (chan)
                    `CSP_CHAN_POS:  src_now = CSP_SRC_POS;
                    `CSP_CHAN_NEG:  src_now = CSP_SRC_NEG;
                    `CSP_CHAN_DIFF: src_now = CSP_SRC_DIFF;
                    `CSP_CHAN_SCAN: begin
                        src_now = alt_q ? CSP_SRC_NEG : CSP_SRC_POS;
                    end
                    default:        src_now = CSP_SRC_NONE;
                endcase
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Next values
    always_comb begin
        setup_d = setup_q;
        pin_d   = CONVERSION_CLOCK_PIN;
        alt_d   = alt_q;
        count_d = count_q;
        ready_d = 1'b0;
        hold_d  = 1'b0;
        ovr_d   = ovr_q;
        src_d   = src_q;
        out_v_d = 1'b0;
        out_d   = out_q;
        st_d    = st_q;
        // Register write, select lines both low
        if (BUS_WRITE && BUS_DATA[11:10] == `CSP_SEL_SETUP0)
            setup_d = BUS_DATA[9:0];
        if (BUS_READ)
            ovr_d = 1'b0;
        case (st_q)
            CSP_ST_IDLE: begin
                // Edge starts a conversion unless powered down
                if (fall && !pwr_down) begin
                    hold_d = setup_q[`CSP_BIT_SINGLE];
                    src_d  = 3'(src_now);
                    st_d   = CSP_ST_CONV;
                end
            end
            CSP_ST_CONV: begin
                // Result captured into the buffer
                out_v_d = 1'b1;
                out_d   = CONV_RESULT;
                if (chan == `CSP_CHAN_SCAN)
                    alt_d = !alt_q;
                if (!to_buf.ready)
                    ovr_d = 1'b1;
                else if (count_q + 4'h1 >= TRIGGER_LEVEL) begin
                    count_d = '0;
                    ready_d = 1'b1;
                end else
                    count_d = count_q + 4'h1;
                st_d = CSP_ST_IDLE;
            end
            default: st_d = CSP_ST_IDLE;
        endcase
        if (chan != `CSP_CHAN_SCAN)
            alt_d = 1'b0;
    end

    // Register stage
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            setup_q <= `CSP_SETUP0_RESET;
            pin_q   <= pin_d;    // Track pin, no false edge after reset
            alt_q   <= 1'b0;
            count_q <= '0;
            ready_q <= 1'b0;
            hold_q  <= 1'b0;
            ovr_q   <= 1'b0;
            src_q   <= '0;
            out_v_q <= 1'b0;
            out_q   <= '0;
            st_q    <= CSP_ST_IDLE;
        end else begin
            setup_q <= setup_d;
            pin_q   <= pin_d;
            alt_q   <= alt_d;
            count_q <= count_d;
            ready_q <= ready_d;
            hold_q  <= hold_d;
            ovr_q   <= ovr_d;
            src_q   <= src_d;
            out_v_q <= out_v_d;
            out_q   <= out_d;
            st_q    <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Buffer wiring; readout works in power down
    assign to_buf.valid   = out_v_q;
    assign to_buf.data    = out_q;
    assign from_buf.ready = BUS_READ;

    // Output word register
    logic        sv_q;
    csp_sample_t sd_q;
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            sv_q <= 1'b0;
            sd_q <= '0;
        end else begin
            sv_q <= BUS_READ && from_buf.valid;
            sd_q <= from_buf.data;
        end
    end

    assign BLOCK_READY_FLAG = ready_q;
    assign SAMPLE_VALID     = sv_q;
    assign SAMPLE_DATA      = sd_q;
    assign SETUP_READBACK   = setup_q;
    assign EXT_REF_SELECT   = setup_q[`CSP_BIT_EXTREF];
    assign HOLD_INPUTS      = hold_q;
    assign SOURCE_SELECT    = src_q;
    assign OVERRUN          = ovr_q;
endmodule : csp_setup

// ===== verification/csp_core_model.sv
// Purpose: analog core stand-in feeding conversion results
// Assumes: result sampled one cycle after the source is set
// Notes:   result tags the chosen source in its top bits
`timescale 1ns/1ns
module csp_core_model (
    input  wire logic [2:0]           SOURCE_SELECT,
    output csp_pkg::csp_sample_t      CONV_RESULT
);
    import csp_pkg::*;
    // Source code in bits 11:9 makes every channel distinct
    assign CONV_RESULT = {SOURCE_SELECT, 9'h0a5};
endmodule : csp_core_model

// ===== verification/csp_setup_properties.sv
// Purpose: port checks of the converter setup block
// Assumes: host writes only listed channel codes
// Notes:   bound to csp_setup below
`timescale 1ns/1ns
module csp_chk (
    input wire logic       CORE_CLK,
    input wire logic       NRST,
    input wire logic       BUS_WRITE,
    input wire logic [11:0] BUS_DATA,
    input wire logic       BUS_READ,
    input wire logic       CONVERSION_CLOCK_PIN,
    input wire logic       BLOCK_READY_FLAG,
    input wire logic       SAMPLE_VALID,
    input wire logic [9:0] SETUP_READBACK,
    input wire logic       EXT_REF_SELECT,
    input wire logic       HOLD_INPUTS,
    input wire logic [2:0] SOURCE_SELECT,
    input wire logic       OVERRUN
);
    import csp_pkg::*;
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////
    a_rst_value: assert property ($rose(NRST) |->
        SETUP_READBACK == 10'h020)
        else $error("setup not at reset value");
    a_wr_load: assert property (BUS_WRITE && BUS_DATA[11:10] == 2'h0
        |=> SETUP_READBACK == $past(BUS_DATA[9:0])) else $error("write lost");
    a_wr_other: assert property (BUS_WRITE && BUS_DATA[11:10] != 2'h0
        |=> $stable(SETUP_READBACK)) else $error("other select hit");
    a_ref_bit: assert property (EXT_REF_SELECT == SETUP_READBACK[0])
        else $error("reference select wrong");
    a_hold_mode: assert property (HOLD_INPUTS
        |-> $past(SETUP_READBACK[2:1]) == 2'b01) else $error("stray hold");
    a_hold_take: assert property ($fell(CONVERSION_CLOCK_PIN)
        && !BUS_WRITE && SETUP_READBACK[2:1] == 2'b01
        |-> ##[1:2] HOLD_INPUTS) else $error("strobe missed");
    a_pd_quiet: assert property (SETUP_READBACK[2] [*4]
        |-> !BLOCK_READY_FLAG && !HOLD_INPUTS) else $error("active in pd");
    a_src_diff: assert property (HOLD_INPUTS
        && $past(SETUP_READBACK[9:3]) == 7'h04
        |-> SOURCE_SELECT == 3'(CSP_SRC_DIFF)) else $error("bad src");
    a_ready_one: assert property (BLOCK_READY_FLAG
        |=> !BLOCK_READY_FLAG) else $error("ready too long");
    a_valid_read: assert property (SAMPLE_VALID |-> $past(BUS_READ))
        else $error("valid without read");
    // Main scenarios reached
    c_hold: cover property (HOLD_INPUTS);
    c_ovr: cover property (OVERRUN);
    c_single_ready: cover property (BLOCK_READY_FLAG && SETUP_READBACK[1]);
endmodule : csp_chk
bind csp_setup csp_chk u_chk (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .BUS_WRITE(BUS_WRITE), .BUS_DATA(BUS_DATA), .BUS_READ(BUS_READ),
    .CONVERSION_CLOCK_PIN(CONVERSION_CLOCK_PIN), .OVERRUN(OVERRUN),
    .BLOCK_READY_FLAG(BLOCK_READY_FLAG), .SAMPLE_VALID(SAMPLE_VALID),
    .SETUP_READBACK(SETUP_READBACK), .EXT_REF_SELECT(EXT_REF_SELECT),
    .HOLD_INPUTS(HOLD_INPUTS), .SOURCE_SELECT(SOURCE_SELECT));

// ===== verification/test_csp_setup.sv
// Purpose: self-checking bench of the converter setup block
// Assumes: core model answers from the source code
// Notes:   table loop first, then hand-written cases
`timescale 1ns/1ns
module test_csp_setup;
    import csp_pkg::*;
    logic        clk, nrst, wr_s, rd_s, pin, rdy, sval, eref, hold, ovr;
    logic [11:0] bdat;
    logic [3:0]  trig;
    logic [9:0]  rb;
    logic [2:0]  src;
    csp_sample_t res, sdat;
    int          err_total, total_checks, nrdy, r, nhld, h;
    // Setup value beside the source it should convert
    logic [12:0] rows [7] = '{{10'h000, 3'h0}, {10'h008, 3'h1},
        {10'h020, 3'h2}, {10'h101, 3'h3}, {10'h200, 3'h4},
        {10'h300, 3'h5}, {10'h022, 3'h2}};
    csp_setup uut (.CORE_CLK(clk), .NRST(nrst), .BUS_WRITE(wr_s),
        .BUS_DATA(bdat), .BUS_READ(rd_s), .CONVERSION_CLOCK_PIN(pin),
        .TRIGGER_LEVEL(trig), .CONV_RESULT(res), .BLOCK_READY_FLAG(rdy),
        .SAMPLE_VALID(sval), .SAMPLE_DATA(sdat), .SETUP_READBACK(rb),
        .EXT_REF_SELECT(eref), .HOLD_INPUTS(hold), .SOURCE_SELECT(src),
        .OVERRUN(ovr));
    csp_core_model u_core (.SOURCE_SELECT(src), .CONV_RESULT(res));
    always #4 clk = ~clk;
    // Count block-ready pulses
    always @(posedge clk) if (rdy === 1'b1) nrdy++;
    // Count hold pulses
    always @(posedge clk) if (hold === 1'b1) nhld++;
    ////////////////////////////////////////////////////////////////////
    task automatic tick; @(posedge clk); #1; endtask : tick
    task automatic chk(input string n, input logic [11:0] e, s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One register write, strobe held over one edge
    task automatic wr(input logic [11:0] d);
        wr_s = 1;
        bdat = d;
        tick;
        wr_s = 0;
        tick;
    endtask : wr
    // One falling edge on the clock pin, then settle
    task automatic fall;
        pin = 0;
        tick;
        pin = 1;
        repeat (4) tick;
    endtask : fall
    // Pop one sample, check it while it stands
    task automatic rd(input logic [11:0] e);
        rd_s = 1;
        tick;
        rd_s = 0;
        chk("valid", 12'h1, 12'(sval));
        chk("data", e, sdat);
        tick;
    endtask : rd
    task automatic wrap_up;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // Watchdog: the run needs about 150 cycles
    initial begin
        #20000;
        err_total++;
        wrap_up;
    end
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk  = 0;
        nrst = 0;
        wr_s = 0;
        rd_s = 0;
        pin  = 1;
        bdat = 0;
        trig = 1;
        repeat (16) @(posedge clk);
        #1 nrst = 1;
        tick;
        chk("reset", 12'h020, 12'(rb));
        foreach (rows[i]) begin
            wr({2'h0, rows[i][12:3]});
            chk("setup", {2'h0, rows[i][12:3]}, 12'(rb));
            chk("ref", 12'(rows[i][3]), 12'(eref));
            r = nrdy;
            h = nhld;
            fall;
            chk("ready", 12'(r + 1), 12'(nrdy));
            chk("hold", 12'(h + rows[i][4]), 12'(nhld));
            rd({rows[i][2:0], 9'h0a5});
        end
        wr(12'h7ff);
        chk("select", 12'h022, 12'(rb));
        // Autoscan samples, read back while powered down
        wr(12'h088);
        repeat (3) fall;
        wr(12'h004);
        r = nrdy;
        fall;
        chk("pd", 12'(r), 12'(nrdy));
        rd(12'h0a5);
        rd(12'h2a5);
        rd(12'h0a5);
        wr(12'h002);
        chk("pd off", 12'h002, 12'(rb));
        // Block of three, then fill the buffer past full
        trig = 3;
        r = nrdy;
        fall;
        fall;
        chk("early", 12'(r), 12'(nrdy));
        fall;
        chk("block", 12'(r + 1), 12'(nrdy));
        fall;
        fall;
        chk("ovr", 12'h1, 12'(ovr));
        rd(12'h0a5);
        chk("ovr clr", 12'h0, 12'(ovr));
        repeat (3) rd(12'h0a5);
        // Reset in mid-run with the setup changed
        nrst = 0;
        tick;
        nrst = 1;
        tick;
        chk("rereset", 12'h020, 12'(rb));
        wrap_up;
    end
endmodule : test_csp_setup
